/* File: output_freeze_map.svh */
// constants for the output freeze serial control block
// assumes inclusion by bare name from the package and the design file
`ifndef OUTPUT_FREEZE_MAP_SVH
`define OUTPUT_FREEZE_MAP_SVH

// freeze enable word
`define FRZ_BITS 12
`define FRZ_CNT_W 4
`define FRZ_LAST_BIT 4'hB
`define FRZ_RESET_WORD 12'hFFF
`define FRZ_START_BIT 1'b0

// register bus
`define WB_ADR_W 8
`define WB_DAT_W 32
`define WB_SEL_W 4
`define REG_STATUS 8'h00
`define REG_CONTROL 8'h04
`define REG_UPDATES 8'h08
`define REG_SHADOW 8'h0C

// register fields
`define CTRL_FORCE_RUN_BIT 0
`define CTRL_RESET_VAL 1'b0
`define UPD_CNT_W 16
`define UPD_CNT_RESET 16'h0000

`endif

/* File: output_freeze_pkg.sv */
// types shared by the output freeze serial control block
// assumes output_freeze_map.svh is on the include path
`include "output_freeze_map.svh"

package output_freeze_pkg;

	// serial receiver states, gray along idle -> shift -> apply
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_SHIFT = 2'b01,
		LINK_APPLY = 2'b11
	} linkState_e;

	// one sampled bus request
	typedef struct packed {
		logic [`WB_ADR_W-1:0] adr;
		logic [`WB_DAT_W-1:0] dat;
		logic [`WB_SEL_W-1:0] sel;
		logic we;
		logic valid;
	} wbReq_s;

	// link receiver state bundle
	typedef struct packed {
		linkState_e state;
		logic [`FRZ_CNT_W-1:0] count;
		logic [`FRZ_BITS-1:0] shift;
	} linkRx_s;

endpackage

/* File: output_freeze_serial_control.sv */
// freeze control for twelve clock outputs, loaded over a two-pin serial link
// assumes the ungated output clocks arrive as levels made on core_clk,
// and the serial clock pin is a clock that may stop between updates
//
// How it works
// - twelve outputs stoppable low via serial word
// - one enable bit per freezable output
// - update opens with start bit zero
// - data sampled on rising serial clock edge
// - enable bit zero freezes its output
// - enable bit one releases its output
// - freeze state unchanged while bits shift
// - apply on edge after twelfth bit
// - bit after twelfth may start next
// - enter freeze only when clock falls
// - leave freeze only when clock rises
`include "output_freeze_map.svh"
`timescale 1ns/1ps
`default_nettype none

module output_freeze_serial_control (
	// core clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// serial freeze link
	input wire logic freezeSerialClock,
	input wire logic freezeSerialData,
	// ungated output clocks and their gated copies
	input wire logic [`FRZ_BITS-1:0] normalClk,
	output logic [`FRZ_BITS-1:0] gatedClk,
	// classic wishbone slave
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [`WB_ADR_W-1:0] wbAdr,
	input wire logic [`WB_SEL_W-1:0] wbSel,
	input wire logic [`WB_DAT_W-1:0] wbDatW,
	output logic [`WB_DAT_W-1:0] wbDatR,
	output logic wbAck
);

	// ---------------- link domain ----------------

	output_freeze_pkg::linkRx_s rx_q;
	output_freeze_pkg::linkRx_s rx_d;
	logic [`FRZ_BITS-1:0] linkWord_q;
	logic [`FRZ_BITS-1:0] linkWord_d;
	logic linkTgl_q;
	logic linkTgl_d;

	// serial receiver next state
	always_comb begin
		rx_d = rx_q;
		linkWord_d = linkWord_q;
		linkTgl_d = linkTgl_q;
		case (rx_q.state)
			output_freeze_pkg::LINK_IDLE: begin
				// wait for a start bit
				if (freezeSerialData == `FRZ_START_BIT) begin
					rx_d.state = output_freeze_pkg::LINK_SHIFT;
					rx_d.count = '0;
				end
			end
			output_freeze_pkg::LINK_SHIFT: begin
				// msb first: first bit lands at index eleven
				rx_d.shift = {rx_q.shift[`FRZ_BITS-2:0], freezeSerialData};
				rx_d.count = rx_q.count + `FRZ_CNT_W'(1);
				if (rx_q.count == `FRZ_LAST_BIT) begin
					rx_d.state = output_freeze_pkg::LINK_APPLY;
				end
			end
			output_freeze_pkg::LINK_APPLY: begin
				// new word becomes visible only here
				linkWord_d = rx_q.shift;
				linkTgl_d = ~linkTgl_q;
				rx_d.count = '0;
				if (freezeSerialData == `FRZ_START_BIT) begin
					rx_d.state = output_freeze_pkg::LINK_SHIFT;
				end else begin
					rx_d.state = output_freeze_pkg::LINK_IDLE;
				end
			end
			default: begin
				rx_d.state = output_freeze_pkg::LINK_IDLE;
				rx_d.count = '0;
			end
		endcase
	end

	// link registers; serial clock may stop, so nothing waits on it here
	always_ff @(posedge freezeSerialClock or negedge arst_n) begin
		if (!arst_n) begin
			rx_q.state <= output_freeze_pkg::LINK_IDLE;
			rx_q.count <= '0;
			rx_q.shift <= `FRZ_RESET_WORD;
			linkWord_q <= `FRZ_RESET_WORD;
			linkTgl_q <= 1'b0;
		end else begin
			rx_q <= rx_d;
			linkWord_q <= linkWord_d;
			linkTgl_q <= linkTgl_d;
		end
	end

	// ---------------- crossing into core domain ----------------

	logic tglS1_q;
	logic tglS2_q;
	logic tglS3_q;
	logic tglS1_d;
	logic tglS2_d;
	logic tglS3_d;
	logic tglSeen_q;
	logic tglSeen_d;
	logic [`FRZ_BITS-1:0] enable_q;
	logic [`FRZ_BITS-1:0] enable_d;
	logic [`UPD_CNT_W-1:0] updCnt_q;
	logic [`UPD_CNT_W-1:0] updCnt_d;
	logic newWord;

	// word is only read after the toggle settles; link holds it for
	// at least twelve serial clocks, far longer than this path takes
	always_comb begin
		// only the second stage reads the first; the third confirms it
		tglS1_d = linkTgl_q;
		tglS2_d = tglS1_q;
		tglS3_d = tglS2_q;
		newWord = (tglS2_q == tglS3_q) && (tglS3_q != tglSeen_q);
		tglSeen_d = tglSeen_q;
		enable_d = enable_q;
		updCnt_d = updCnt_q;
		if (newWord) begin
			tglSeen_d = tglS3_q;
			enable_d = linkWord_q;
			updCnt_d = updCnt_q + `UPD_CNT_W'(1);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tglS1_q <= 1'b0;
			tglS2_q <= 1'b0;
			tglS3_q <= 1'b0;
			tglSeen_q <= 1'b0;
			enable_q <= `FRZ_RESET_WORD;
			updCnt_q <= `UPD_CNT_RESET;
		end else begin
			tglS1_q <= tglS1_d;
			tglS2_q <= tglS2_d;
			tglS3_q <= tglS3_d;
			tglSeen_q <= tglSeen_d;
			enable_q <= enable_d;
			updCnt_q <= updCnt_d;
		end
	end

	// ---------------- glitch-free output gating ----------------

	logic forceRun_q;
	logic [`FRZ_BITS-1:0] runEn_q;
	wire logic [`FRZ_BITS-1:0] runEn_d;
	wire logic [`FRZ_BITS-1:0] gated_d;
	logic [`FRZ_BITS-1:0] wantRun;

	// force bit overrides the received word
	always_comb begin
		wantRun = enable_q | {`FRZ_BITS{forceRun_q}};
	end

	// one gate cell per output; the effective enable only moves while
	// the clock is low, so the output can neither be cut short nor
	// start mid-pulse
	for (genvar i = 0; i < `FRZ_BITS; i++) begin : g_gate
		logic cellEn;
		always_comb begin
			if (normalClk[i]) begin
				cellEn = runEn_q[i];
			end else begin
				cellEn = wantRun[i];
			end
		end
		assign runEn_d[i] = cellEn;
		// a frozen cell holds its output low
		assign gated_d[i] = normalClk[i] & cellEn;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			runEn_q <= `FRZ_RESET_WORD;
			gatedClk <= '0;
		end else begin
			runEn_q <= runEn_d;
			gatedClk <= gated_d;
		end
	end

	// ---------------- wishbone slave ----------------

	output_freeze_pkg::wbReq_s req;
	logic ack_d;
	logic [`WB_DAT_W-1:0] datR_d;
	logic forceRun_d;

	// answer one cycle after the strobe, drop the cycle after
	always_comb begin
		req.adr = wbAdr;
		req.dat = wbDatW;
		req.sel = wbSel;
		req.we = wbWe;
		req.valid = wbCyc & wbStb & ~wbAck;
		ack_d = req.valid;
		forceRun_d = forceRun_q;
		datR_d = '0;
		if (req.valid) begin
			case (req.adr)
				`REG_STATUS: begin
					datR_d[`FRZ_BITS-1:0] = runEn_q;
				end
				`REG_CONTROL: begin
					datR_d[`CTRL_FORCE_RUN_BIT] = forceRun_q;
					if (req.we && req.sel[0]) begin
						forceRun_d = req.dat[`CTRL_FORCE_RUN_BIT];
					end
				end
				`REG_UPDATES: begin
					datR_d[`UPD_CNT_W-1:0] = updCnt_q;
				end
				`REG_SHADOW: begin
					datR_d[`FRZ_BITS-1:0] = enable_q;
				end
				// unmapped: acked, reads zero, writes dropped
				default: begin
					datR_d = '0;
				end
			endcase
			if (req.we) begin
				datR_d = '0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wbAck <= 1'b0;
			wbDatR <= '0;
			forceRun_q <= `CTRL_RESET_VAL;
		end else begin
			wbAck <= ack_d;
			wbDatR <= datR_d;
			forceRun_q <= forceRun_d;
		end
	end

endmodule

`default_nettype wire

/* File: output_freeze_serial_control_assertions.sv */
// checker for the freeze control block
// assumes it is bound onto the design top
`include "output_freeze_map.svh"
`timescale 1ns/1ps
`default_nettype none
module output_freeze_serial_control_assertions (
	// core
	input wire logic core_clk,
	input wire logic arst_n,
	// outputs
	input wire logic [`FRZ_BITS-1:0] normalClk,
	input wire logic [`FRZ_BITS-1:0] gatedClk,
	// bus
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [`WB_DAT_W-1:0] wbDatR,
	input wire logic wbAck
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence takeS;
		wbCyc && wbStb && !wbAck;
	endsequence
	AST_ACK: assert property (takeS |=> wbAck) else $error("no ack");
	AST_ACK_ONE: assert property (wbAck |=> !wbAck) else $error("long ack");
	AST_ACK_CAUSE: assert property ($rose(wbAck) |-> $past(wbCyc && wbStb)) else $error("stray ack");
	AST_DAT_IDLE: assert property (!wbAck |-> wbDatR == '0) else $error("idle data");
	AST_WR_ZERO: assert property (wbAck && $past(wbWe) |-> wbDatR == '0) else $error("write data");
	AST_LOW_ONLY: assert property ((gatedClk & ~$past(normalClk)) == '0) else $error("high");
	AST_FALL_SYNC: assert property ((~gatedClk & $past(gatedClk & normalClk)) == '0)
		else $error("runt fall");
	// skip the first edges, gating follows at once after reset
	AST_RISE_SYNC: assert property ($past(arst_n, 3) |->
		(gatedClk & ~$past(gatedClk) & $past(normalClk, 2)) == '0) else $error("runt rise");
endmodule
bind output_freeze_serial_control output_freeze_serial_control_assertions chk (.core_clk,
	.arst_n, .normalClk, .gatedClk, .wbCyc, .wbStb, .wbWe, .wbDatR, .wbAck);
`default_nettype wire

/* File: freeze_link_model.sv */
// controller driving the serial freeze pins
// assumes callers send bits one after another
`timescale 1ns/1ps
`default_nettype none
module freeze_link_model (
	// serial pins
	output var logic freezeSerialClock,
	output var logic freezeSerialData
);
	initial begin
		freezeSerialClock = 1'b0;
		freezeSerialData = 1'b1;
	end
	// clock rests low outside frames
	task automatic step(input logic d);
		freezeSerialData = d;
		#7.5 freezeSerialClock = 1'b1;
		#7.5 freezeSerialClock = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: output_freeze_serial_control_tb_top.sv */
// self-checking bench for the freeze control block
// assumes link model and checker compiled first
`include "output_freeze_map.svh"
`timescale 1ns/1ps
`default_nettype none
module output_freeze_serial_control_tb_top;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic wbCyc, wbStb, wbWe, wbAck, freezeSerialClock, freezeSerialData;
	logic [`FRZ_BITS-1:0] normalClk, gatedClk;
	logic [`WB_ADR_W-1:0] wbAdr;
	logic [`WB_DAT_W-1:0] wbDatW, wbDatR;
	logic [`WB_SEL_W-1:0] wbSel;
	logic [3:0] div = '0;
	int err_count = 0, check_count = 0, cycles = 0;
	always #2.5 core_clk = ~core_clk;
	freeze_link_model link (.freezeSerialClock, .freezeSerialData);
	output_freeze_serial_control dut (.core_clk, .arst_n, .freezeSerialClock, .freezeSerialData,
		.normalClk, .gatedClk, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR,
		.wbAck);
	// two output rates, so gating meets both phases
	always @(posedge core_clk) begin
		div <= div + 4'h1;
		// low in reset so no output starts mid-pulse
		normalClk <= arst_n ? {6{div[2:1]}} : '0;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			print_verdict();
		end
	end
	task print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// writes read back zero as well
	task wbs(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
		input logic [3:0] s);
		@(posedge core_clk);
		{wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} <= {2'h3, we, a, d, s};
		do @(posedge core_clk); while (wbAck !== 1'b1);
		cmp(wbDatR, e);
		{wbCyc, wbStb} <= 2'h0;
		@(posedge core_clk);
		#1;
	endtask
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		wbs(we, a, d, e, 4'hF);
	endtask
	// settle, then every running output must pulse within one slow period
	task seen(input logic [11:0] w);
		logic [11:0] acc;
		acc = '0;
		repeat (8) @(posedge core_clk);
		repeat (8) begin
			@(posedge core_clk);
			acc = acc | gatedClk;
		end
		cmp(32'(acc), 32'(w));
		#1;
	endtask
	task bits(input logic [11:0] w, input int hi, input int lo);
		for (int i = hi; i >= lo; i--)
			link.step(w[i]);
		repeat (16) @(posedge core_clk);
		#1;
	endtask
	// p is the word still in force until the apply edge
	task word(input logic [11:0] w, input logic [11:0] p);
		link.step(1'b0);
		link.step(w[11]);
		bits(w, 10, 0);
		wb(1'b0, `REG_STATUS, 32'h0, 32'(p));
		link.step(1'b1);
		bits(w, -1, 0);
		wb(1'b0, `REG_STATUS, 32'h0, 32'(w));
		wb(1'b0, `REG_SHADOW, 32'h0, 32'(w));
		cmp(32'(gatedClk & ~w), 32'h0);
		seen(w);
	endtask
	initial begin
		{wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} <= '0;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		wb(1'b0, `REG_STATUS, 32'h0, 32'hFFF);
		wb(1'b0, 8'h10, 32'h0, 32'h0);
		wb(1'b1, `REG_CONTROL, 32'h1, 32'h0);
		wb(1'b0, `REG_CONTROL, 32'h0, 32'h1);
		wb(1'b1, `REG_CONTROL, 32'h0, 32'h0);
		link.step(1'b1);
		word(12'hA5C, 12'hFFF);
		word(12'h000, 12'hA5C);
		wbs(1'b1, `REG_CONTROL, 32'h1, 32'h0, 4'hE);
		wb(1'b0, `REG_CONTROL, 32'h0, 32'h0);
		wb(1'b1, `REG_CONTROL, 32'h1, 32'h0);
		seen(12'hFFF);
		wb(1'b0, `REG_STATUS, 32'h0, 32'hFFF);
		wb(1'b0, `REG_SHADOW, 32'h0, 32'h0);
		wb(1'b1, `REG_CONTROL, 32'h0, 32'h0);
		seen(12'h000);
		word(12'hFFF, 12'h000);
		word(12'h3C3, 12'hFFF);
		link.step(1'b0);
		bits(12'h81E, 11, 6);
		wb(1'b0, `REG_STATUS, 32'h0, 32'h3C3);
		bits(12'h81E, 5, 0);
		link.step(1'b0);
		bits(12'h0, -1, 0);
		wb(1'b0, `REG_STATUS, 32'h0, 32'h81E);
		bits(12'hFFF, 11, 0);
		link.step(1'b1);
		bits(12'h0, -1, 0);
		wb(1'b0, `REG_UPDATES, 32'h0, 32'h6);
		print_verdict();
	end
endmodule
`default_nettype wire
